// ==== hdl/sff_map.svh ====
`ifndef SFF_MAP_SVH
`define SFF_MAP_SVH

// Instruction codes
`define SFF_OP_WREN 8'h10
`define SFF_OP_WRDI 8'h11
`define SFF_OP_RDSR1 8'h12
`define SFF_OP_RDSR2 8'h13
`define SFF_OP_WRSR 8'h14
`define SFF_OP_PROG 8'h20
`define SFF_OP_SECTOR 8'h21
`define SFF_OP_BLK32 8'h22
`define SFF_OP_BLK64 8'h23
`define SFF_OP_CHIP 8'h24
`define SFF_OP_SEC_ERASE 8'h25
`define SFF_OP_SEC_PROG 8'h26
`define SFF_OP_PDOWN 8'h30
`define SFF_OP_RPDOWN 8'h31
`define SFF_OP_SUSPEND 8'h32
`define SFF_OP_RESUME 8'h33
`define SFF_OP_READ 8'h40
`define SFF_OP_FAST 8'h41
`define SFF_OP_DUAL_OUT 8'h3B
`define SFF_OP_DUAL_IO 8'hBB
`define SFF_OP_QUAD_OUT 8'h6B
`define SFF_OP_QUAD_IO 8'hEB
`define SFF_OP_QUAD_WORD 8'hE7
`define SFF_OP_QUAD_OCTAL 8'hE3

// Status word bit positions
`define SFF_SR_BUSY 0
`define SFF_SR_WEL 1
`define SFF_SR_SRP0 7
`define SFF_SR_SRP1 8
`define SFF_SR_QE 9
`define SFF_SR_SUS 15
`define SFF_SR_WMASK 16'h43FC
`define SFF_SR_OTPMASK 16'h3C00
`define SFF_SR_RESET 16'h0000

// Counts
`define SFF_OPCODE_BITS 6'h08
`define SFF_ABITS_24 6'h18
`define SFF_ABITS_32 6'h20
`define SFF_SYNC_RST 6'h22

// Timing
`define SFF_CLK_NS 8
`define SFF_PUW_NS 10000
`define SFF_PUW_CYCLES ((`SFF_PUW_NS + `SFF_CLK_NS - 1) / `SFF_CLK_NS)

`endif

// ==== hdl/sff_pkg.sv ====
package sff_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_OPCODE = 7'h02,
    ST_ADDR = 7'h04,
    ST_DUMMY = 7'h08,
    ST_WDATA = 7'h10,
    ST_RDATA = 7'h20,
    ST_DONE = 7'h40
  } sff_state_e;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_PROG = 4'h1,
    OP_SECTOR = 4'h2,
    OP_BLK32 = 4'h3,
    OP_BLK64 = 4'h4,
    OP_CHIP = 4'h5,
    OP_WRSR = 4'h6,
    OP_SEC_ERASE = 4'h7,
    OP_SEC_PROG = 4'h8
  } sff_op_e;

  typedef struct packed {
    logic ok;
    logic wr;
    logic needw;
    logic quad;
    sff_state_e first;
    sff_state_e post;
    logic [5:0] aw;
    logic [5:0] abits;
    logic [5:0] dummy;
    logic [5:0] dw;
  } sff_dec_s;

endpackage : sff_pkg

// ==== hdl/sff_pins_if.sv ====
`timescale 1ns/1ns
interface sff_pins_if;
  logic sclk;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_n;
  logic cs_rise;
  logic [3:0] lane;
  modport src (output sclk, output sclk_rise, output sclk_fall, output cs_n, output cs_rise,
    output lane);
  modport dst (input sclk, input sclk_rise, input sclk_fall, input cs_n, input cs_rise,
    input lane);
endinterface : sff_pins_if

// ==== hdl/sff_pin_sync.sv ====
`timescale 1ns/1ns
`include "sff_map.svh"
module sff_pin_sync (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] lane_i,
  sff_pins_if.src pin
);
  localparam logic [5:0] RST_VAL = `SFF_SYNC_RST;
  logic [5:0] raw;
  logic [5:0] s2;
  logic [5:0] s3;

  assign raw = {lane_i, cs_n_i, sclk_i};

  // Two-stage synchronisers plus one delay stage for edges
  for (genvar g = 0; g < 6; g++) begin : g_sync
    logic m1;
    logic m2;
    logic m3;
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        m1 <= RST_VAL[g];
        m2 <= RST_VAL[g];
        m3 <= RST_VAL[g];
      end else begin
        m1 <= raw[g];
        m2 <= m1;
        m3 <= m2;
      end
    end
    assign s2[g] = m2;
    assign s3[g] = m3;
  end

  assign pin.sclk = s2[0];
  assign pin.sclk_rise = s2[0] & ~s3[0];
  assign pin.sclk_fall = ~s2[0] & s3[0];
  assign pin.cs_n = s2[1];
  assign pin.cs_rise = s2[1] & ~s3[1];
  assign pin.lane = s2[5:2];
endmodule : sff_pin_sync

// ==== hdl/sff_front_end.sv ====
`timescale 1ns/1ns
`include "sff_map.svh"
// Operation
// - Single lane samples serial_in on clock rise
// - Single lane drives serial_out on clock fall
// - Clock modes 0 and 3 supported
// - Dual reads use lane0 and lane1
// - Quad reads use all four lanes
// - Quad instructions need quad_lane_enable set
// - Pause only outside four-lane operation, selected
// - Pause starts when pause low, clock low
// - Pause ends when pause high, clock low
// - Paused: outputs off, inputs ignored, state kept
// - Power-on reset disables everything
// - Write-type instructions refused until delay elapses
// - Latch cleared at power-up
// - Writes need write_enable_latch set
// - Latch cleared by disable and completion
// - Power-down ignores all but release
// - Status write gated by lock mode, pin
// - Busy flag S0 tracks running operation
// - Busy ignores all but status read, suspend
// - Write enable sets latch at S1
// - block_guard_bits S4..S2 writable, default zero
// - Deselected: lanes released, operation continues
// - Quad enable turns protect, pause pins into lanes
// - Hardware lock: protect low refuses status write
module sff_front_end #(
  parameter int PUW_CYCLES = `SFF_PUW_CYCLES
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] lane_i,
  output logic [3:0] lane_o,
  output logic [3:0] lane_oe_n_o,
  input wire logic op_done_i,
  input wire logic [7:0] rd_data_i,
  output logic [23:0] rd_addr_o,
  output logic rd_next_o,
  output logic [7:0] wr_byte_o,
  output logic wr_valid_o,
  output logic op_start_o,
  output sff_pkg::sff_op_e op_kind_o,
  output logic [23:0] op_addr_o,
  output logic suspend_o,
  output logic resume_o,
  output logic [15:0] status_o,
  output logic busy_o,
  output logic powered_down_o,
  output logic paused_o,
  output logic write_ready_o
);
  sff_pins_if pin ();

  sff_pin_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .lane_i(lane_i),
    .pin(pin.src)
  );

  sff_pkg::sff_state_e state;
  sff_pkg::sff_dec_s dec;
  sff_pkg::sff_dec_s cur;
  logic [7:0] cmd;
  logic cmd_ok;
  logic [31:0] rx;
  logic [31:0] next_rx;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [5:0] in_w;
  logic addr_done;
  logic paused;
  logic write_enable_latch;
  logic busy;
  logic pd;
  logic sus;
  logic [15:0] status_nv;
  logic [15:0] status_word;
  logic [15:0] next_sr;
  logic [7:0] wrsr_b0;
  logic [7:0] wrsr_b1;
  logic [1:0] wr_bytes;
  logic [7:0] tx_byte;
  logic [7:0] load_byte;
  logic [7:0] src_byte;
  logic [5:0] tx_left;
  logic [3:0] tx_mask;
  logic [31:0] puw_cnt;
  logic puw_done;
  logic qe;
  logic wrsr_allowed;
  logic edge_in;
  logic addr_fin;
  logic byte_fin;
  logic exec;
  logic [23:0] addr24;

  assign qe = status_nv[`SFF_SR_QE];
  assign edge_in = pin.sclk_rise & ~paused & ~pin.cs_n;
  assign addr_fin = edge_in & (state == sff_pkg::ST_ADDR) & (next_cnt == cur.abits);
  assign byte_fin = edge_in & (state == sff_pkg::ST_WDATA) & (next_cnt == `SFF_OPCODE_BITS);
  assign exec = pin.cs_rise & cmd_ok;
  assign addr24 = (cur.abits == `SFF_ABITS_32) ? next_rx[31:8] : next_rx[23:0];

  // Input shifter, highest lane in use carries the MSB
  always_comb begin
    in_w = (state == sff_pkg::ST_ADDR) ? cur.aw : 6'h01;
    case (in_w)
      6'h04: next_rx = {rx[27:0], pin.lane[3:0]};
      6'h02: next_rx = {rx[29:0], pin.lane[1:0]};
      default: next_rx = {rx[30:0], pin.lane[0]};
    endcase
    next_cnt = cnt + in_w;
  end

  // Status write permission
  always_comb begin
    case ({status_nv[`SFF_SR_SRP1], status_nv[`SFF_SR_SRP0]})
      2'b00: wrsr_allowed = 1'b1;
      2'b01: wrsr_allowed = qe | pin.lane[2];
      default: wrsr_allowed = 1'b0;
    endcase
  end

  // Opcode decode and gating
  always_comb begin
    dec = '0;
    dec.first = sff_pkg::ST_DONE;
    dec.post = sff_pkg::ST_DONE;
    dec.aw = 6'h01;
    dec.abits = `SFF_ABITS_24;
    dec.dw = 6'h01;
    dec.ok = 1'b1;
    case (next_rx[7:0])
      `SFF_OP_WREN: dec.wr = 1'b1;
      `SFF_OP_WRDI, `SFF_OP_PDOWN, `SFF_OP_RPDOWN, `SFF_OP_SUSPEND, `SFF_OP_RESUME: ;
      `SFF_OP_RDSR1, `SFF_OP_RDSR2: dec.first = sff_pkg::ST_RDATA;
      `SFF_OP_WRSR: begin
        dec.first = sff_pkg::ST_WDATA;
        dec.wr = 1'b1;
        dec.needw = 1'b1;
        dec.ok = wrsr_allowed;
      end
      `SFF_OP_PROG, `SFF_OP_SEC_PROG: begin
        dec.first = sff_pkg::ST_ADDR;
        dec.post = sff_pkg::ST_WDATA;
        dec.wr = 1'b1;
        dec.needw = 1'b1;
      end
      `SFF_OP_SECTOR, `SFF_OP_BLK32, `SFF_OP_BLK64, `SFF_OP_SEC_ERASE: begin
        dec.first = sff_pkg::ST_ADDR;
        dec.wr = 1'b1;
        dec.needw = 1'b1;
      end
      `SFF_OP_CHIP: begin
        dec.wr = 1'b1;
        dec.needw = 1'b1;
      end
      `SFF_OP_READ, `SFF_OP_FAST: begin
        dec.first = sff_pkg::ST_ADDR;
        dec.post = sff_pkg::ST_RDATA;
        dec.dummy = (next_rx[7:0] == `SFF_OP_FAST) ? 6'h08 : 6'h00;
      end
      `SFF_OP_DUAL_OUT, `SFF_OP_QUAD_OUT: begin
        dec.first = sff_pkg::ST_ADDR;
        dec.post = sff_pkg::ST_RDATA;
        dec.dummy = 6'h08;
        dec.quad = (next_rx[7:0] == `SFF_OP_QUAD_OUT);
        dec.dw = dec.quad ? 6'h04 : 6'h02;
      end
      `SFF_OP_DUAL_IO: begin
        dec.first = sff_pkg::ST_ADDR;
        dec.post = sff_pkg::ST_RDATA;
        dec.aw = 6'h02;
        dec.abits = `SFF_ABITS_32;
        dec.dw = 6'h02;
      end
      `SFF_OP_QUAD_IO, `SFF_OP_QUAD_WORD, `SFF_OP_QUAD_OCTAL: begin
        dec.first = sff_pkg::ST_ADDR;
        dec.post = sff_pkg::ST_RDATA;
        dec.aw = 6'h04;
        dec.abits = `SFF_ABITS_32;
        dec.dw = 6'h04;
        dec.quad = 1'b1;
        if (next_rx[7:0] == `SFF_OP_QUAD_IO) dec.dummy = 6'h04;
        else if (next_rx[7:0] == `SFF_OP_QUAD_WORD) dec.dummy = 6'h02;
      end
      default: dec.ok = 1'b0;
    endcase
    if (pd && next_rx[7:0] != `SFF_OP_RPDOWN) dec.ok = 1'b0;
    if (busy && next_rx[7:0] != `SFF_OP_RDSR1 && next_rx[7:0] != `SFF_OP_RDSR2
        && next_rx[7:0] != `SFF_OP_SUSPEND) dec.ok = 1'b0;
    if (!puw_done && dec.wr) dec.ok = 1'b0;
    if (dec.needw && !write_enable_latch) dec.ok = 1'b0;
    if (dec.quad && !qe) dec.ok = 1'b0;
    if (!dec.ok) dec.first = sff_pkg::ST_DONE;
  end

  // Instruction sequencer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= sff_pkg::ST_IDLE;
      cnt <= 6'h00;
      rx <= 32'h0000_0000;
      cmd <= 8'h00;
      cmd_ok <= 1'b0;
      cur <= '0;
      addr_done <= 1'b0;
    end else if (pin.cs_n) begin
      state <= sff_pkg::ST_IDLE;
      cnt <= 6'h00;
      addr_done <= 1'b0;
    end else if (state == sff_pkg::ST_IDLE) begin
      state <= sff_pkg::ST_OPCODE;
      cnt <= 6'h00;
      cmd_ok <= 1'b0;
    end else if (edge_in) begin
      case (state)
        sff_pkg::ST_OPCODE: begin
          rx <= next_rx;
          cnt <= next_cnt;
          if (next_cnt == `SFF_OPCODE_BITS) begin
            cmd <= next_rx[7:0];
            cmd_ok <= dec.ok;
            cur <= dec;
            state <= dec.first;
            cnt <= 6'h00;
          end
        end
        sff_pkg::ST_ADDR: begin
          rx <= next_rx;
          cnt <= next_cnt;
          if (addr_fin) begin
            addr_done <= 1'b1;
            cnt <= 6'h00;
            state <= (cur.dummy != 6'h00) ? sff_pkg::ST_DUMMY : cur.post;
          end
        end
        sff_pkg::ST_DUMMY: begin
          cnt <= cnt + 6'h01;
          if (cnt + 6'h01 == cur.dummy) begin
            cnt <= 6'h00;
            state <= cur.post;
          end
        end
        sff_pkg::ST_WDATA: begin
          rx <= next_rx;
          cnt <= byte_fin ? 6'h00 : next_cnt;
        end
        default: ;
      endcase
    end
  end

  // Pause control
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || pin.cs_n || qe) begin
      paused <= 1'b0;
    end else if (!pin.sclk) begin
      paused <= ~pin.lane[3];
    end
  end

  // Write data capture
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_byte_o <= 8'h00;
      wr_valid_o <= 1'b0;
      wrsr_b0 <= 8'h00;
      wrsr_b1 <= 8'h00;
      wr_bytes <= 2'h0;
    end else begin
      wr_valid_o <= byte_fin & cmd_ok & (cmd != `SFF_OP_WRSR);
      if (state == sff_pkg::ST_IDLE) wr_bytes <= 2'h0;
      if (byte_fin) begin
        wr_byte_o <= next_rx[7:0];
        if (wr_bytes == 2'h0) wrsr_b0 <= next_rx[7:0];
        if (wr_bytes == 2'h1) wrsr_b1 <= next_rx[7:0];
        if (wr_bytes != 2'h3) wr_bytes <= wr_bytes + 2'h1;
      end
    end
  end

  // Output shifter
  always_comb begin
    if (cmd == `SFF_OP_RDSR1) load_byte = status_word[7:0];
    else if (cmd == `SFF_OP_RDSR2) load_byte = status_word[15:8];
    else load_byte = rd_data_i;
    src_byte = (tx_left == 6'h00) ? load_byte : tx_byte;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lane_o <= 4'h0;
      lane_oe_n_o <= 4'hF;
      tx_byte <= 8'h00;
      tx_left <= 6'h00;
      tx_mask <= 4'hF;
      rd_addr_o <= 24'h00_0000;
      rd_next_o <= 1'b0;
    end else begin
      rd_next_o <= 1'b0;
      if (addr_fin) rd_addr_o <= addr24;
      if (state != sff_pkg::ST_RDATA || pin.cs_n) begin
        lane_oe_n_o <= 4'hF;
        tx_left <= 6'h00;
        tx_mask <= 4'hF;
      end else if (paused) begin
        lane_oe_n_o <= 4'hF;
      end else if (pin.sclk_fall) begin
        case (cur.dw)
          6'h04: begin
            lane_o <= src_byte[7:4];
            tx_byte <= {src_byte[3:0], 4'h0};
            tx_mask <= 4'h0;
            lane_oe_n_o <= 4'h0;
          end
          6'h02: begin
            lane_o <= {2'h0, src_byte[7:6]};
            tx_byte <= {src_byte[5:0], 2'h0};
            tx_mask <= 4'hC;
            lane_oe_n_o <= 4'hC;
          end
          default: begin
            lane_o <= {2'h0, src_byte[7], 1'b0};
            tx_byte <= {src_byte[6:0], 1'b0};
            tx_mask <= 4'hD;
            lane_oe_n_o <= 4'hD;
          end
        endcase
        tx_left <= ((tx_left == 6'h00) ? 6'h08 : tx_left) - cur.dw;
        if (tx_left == 6'h00 && cmd != `SFF_OP_RDSR1 && cmd != `SFF_OP_RDSR2) begin
          rd_addr_o <= rd_addr_o + 24'h00_0001;
          rd_next_o <= 1'b1;
        end
      end else begin
        lane_oe_n_o <= tx_mask;
      end
    end
  end

  // Status word view
  always_comb begin
    status_word = status_nv & (`SFF_SR_WMASK | `SFF_SR_OTPMASK);
    status_word[`SFF_SR_BUSY] = busy;
    status_word[`SFF_SR_WEL] = write_enable_latch;
    status_word[`SFF_SR_SUS] = sus;
    next_sr = {(wr_bytes[1] ? wrsr_b1 : status_nv[15:8]), wrsr_b0};
    next_sr = (status_nv & ~`SFF_SR_WMASK) | (next_sr & `SFF_SR_WMASK)
      | (next_sr & `SFF_SR_OTPMASK);
  end

  // Execution at deselect
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      write_enable_latch <= 1'b0;
      busy <= 1'b0;
      pd <= 1'b0;
      sus <= 1'b0;
      status_nv <= `SFF_SR_RESET;
      op_start_o <= 1'b0;
      op_kind_o <= sff_pkg::OP_NONE;
      op_addr_o <= 24'h00_0000;
      suspend_o <= 1'b0;
      resume_o <= 1'b0;
      status_o <= `SFF_SR_RESET;
    end else begin
      op_start_o <= 1'b0;
      suspend_o <= 1'b0;
      resume_o <= 1'b0;
      status_o <= status_word;
      if (op_done_i && busy) begin
        busy <= 1'b0;
        write_enable_latch <= 1'b0;
      end
      if (addr_fin) op_addr_o <= addr24;
      if (exec) begin
        case (cmd)
          `SFF_OP_WREN: write_enable_latch <= 1'b1;
          `SFF_OP_WRDI: write_enable_latch <= 1'b0;
          `SFF_OP_PDOWN: pd <= 1'b1;
          `SFF_OP_RPDOWN: pd <= 1'b0;
          `SFF_OP_SUSPEND: if (busy) begin
            busy <= 1'b0;
            sus <= 1'b1;
            suspend_o <= 1'b1;
          end
          `SFF_OP_RESUME: if (sus) begin
            busy <= 1'b1;
            sus <= 1'b0;
            resume_o <= 1'b1;
          end
          `SFF_OP_WRSR: if (wr_bytes != 2'h0) begin
            status_nv <= next_sr;
            busy <= 1'b1;
            op_start_o <= 1'b1;
            op_kind_o <= sff_pkg::OP_WRSR;
          end
          `SFF_OP_CHIP: begin
            busy <= 1'b1;
            op_start_o <= 1'b1;
            op_kind_o <= sff_pkg::OP_CHIP;
          end
          `SFF_OP_PROG, `SFF_OP_SEC_PROG, `SFF_OP_SECTOR, `SFF_OP_BLK32, `SFF_OP_BLK64,
          `SFF_OP_SEC_ERASE: if (addr_done) begin
            busy <= 1'b1;
            op_start_o <= 1'b1;
            case (cmd)
              `SFF_OP_PROG: op_kind_o <= sff_pkg::OP_PROG;
              `SFF_OP_SEC_PROG: op_kind_o <= sff_pkg::OP_SEC_PROG;
              `SFF_OP_SECTOR: op_kind_o <= sff_pkg::OP_SECTOR;
              `SFF_OP_BLK32: op_kind_o <= sff_pkg::OP_BLK32;
              `SFF_OP_BLK64: op_kind_o <= sff_pkg::OP_BLK64;
              default: op_kind_o <= sff_pkg::OP_SEC_ERASE;
            endcase
          end
          default: ;
        endcase
      end
    end
  end

  // Power-up write delay
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      puw_cnt <= 32'(PUW_CYCLES);
      puw_done <= 1'b0;
    end else if (puw_cnt != 32'h0000_0000) begin
      puw_cnt <= puw_cnt - 32'h0000_0001;
    end else begin
      puw_done <= 1'b1;
    end
  end

  assign busy_o = busy;
  assign powered_down_o = pd;
  assign paused_o = paused;
  assign write_ready_o = puw_done;
endmodule : sff_front_end

// ==== tb/sff_front_end_props.sv ====
`timescale 1ns/1ns
`include "sff_map.svh"
module sff_front_end_props #(
  parameter int PUW_CYCLES = 1250
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n_i,
  input wire logic op_done_i,
  input wire logic [3:0] lane_oe_n_o,
  input wire logic op_start_o,
  input wire logic [15:0] status_o,
  input wire logic busy_o,
  input wire logic powered_down_o,
  input wire logic paused_o,
  input wire logic write_ready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  int unsigned since_rst;
  // Cycles since reset release, saturating
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      since_rst <= 0;
    end else if (since_rst < PUW_CYCLES) begin
      since_rst <= since_rst + 1;
    end
  end
  sequence finish_seen;
    busy_o && op_done_i;
  endsequence
  sequence latch_gone;
    ##[1:3] (!busy_o && !status_o[`SFF_SR_WEL]);
  endsequence
  idle_release_a: assert property (cs_n_i [*6] |-> lane_oe_n_o == 4'hF)
    else $error("lanes driven while deselected");
  pause_release_a: assert property (paused_o && $past(paused_o) |-> lane_oe_n_o == 4'hF)
    else $error("lanes driven while paused");
  pause_single_a: assert property (paused_o |-> !status_o[`SFF_SR_QE])
    else $error("pause taken with quad lanes enabled");
  quad_gate_a: assert property (lane_oe_n_o == 4'h0 |-> status_o[`SFF_SR_QE])
    else $error("four lanes driven without quad enable");
  warmup_gate_a: assert property (since_rst < PUW_CYCLES |-> !write_ready_o && !op_start_o)
    else $error("write activity before power-up delay");
  start_latch_a: assert property (op_start_o |-> status_o[`SFF_SR_WEL] ##[0:2] status_o[`SFF_SR_BUSY])
    else $error("operation started without latch or busy");
  finish_clear_a: assert property (finish_seen |-> latch_gone)
    else $error("completion did not clear busy and latch");
  quiet_busy_a: assert property (busy_o && $past(busy_o) |-> !op_start_o)
    else $error("operation started while busy");
  sleep_quiet_a: assert property (powered_down_o && $past(powered_down_o) |-> !op_start_o)
    else $error("operation started while powered down");
  reset_clean_a: assert property ($fell(sys_rst_i) |-> status_o == 16'h0000 && !busy_o)
    else $error("status not clear after reset");
  busy_shown_a: assert property (busy_o [*3] |-> status_o[`SFF_SR_BUSY])
    else $error("busy flag not shown in status");
endmodule : sff_front_end_props

bind sff_front_end sff_front_end_props #(.PUW_CYCLES(PUW_CYCLES)) sff_front_end_props_inst (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .cs_n_i(cs_n_i),
  .op_done_i(op_done_i),
  .lane_oe_n_o(lane_oe_n_o),
  .op_start_o(op_start_o),
  .status_o(status_o),
  .busy_o(busy_o),
  .powered_down_o(powered_down_o),
  .paused_o(paused_o),
  .write_ready_o(write_ready_o)
);

// ==== tb/sff_spi_master.sv ====
`timescale 1ns/1ns
module sff_spi_master (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  output logic pause_n_o,
  input wire logic miso_i,
  input wire logic paused_i,
  input wire logic [3:0] oe_n_i
);
  localparam int HALF = 80;
  logic mode3;
  logic paused_seen;
  logic [3:0] oe_seen;
  logic [3:0] pause_oe;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    pause_n_o = 1'b1;
    mode3 = 1'b0;
  end
  // One clock: data set while low, answer taken at the rise
  task automatic clk_bit(input logic b, output logic r);
    sclk_o = 1'b0;
    mosi_o = b;
    #HALF;
    sclk_o = 1'b1;
    r = miso_i;
    oe_seen = oe_n_i;
    #HALF;
  endtask : clk_bit
  // Pause with clock low, clock wiggled meanwhile
  task automatic hold_bus();
    sclk_o = 1'b0;
    #HALF;
    pause_n_o = 1'b0;
    #HALF;
    paused_seen = paused_i;
    pause_oe = oe_n_i;
    repeat (2) begin
      sclk_o = 1'b1;
      mosi_o = ~mosi_o;
      #HALF;
      sclk_o = 1'b0;
      #HALF;
    end
    pause_n_o = 1'b1;
    #HALF;
  endtask : hold_bus
  task automatic frame(input logic [7:0] op, input logic [23:0] arg, input int narg,
      input int nrd, input int pause_at, output logic [7:0] rd);
    logic r;
    rd = 8'h00;
    if (sclk_o !== mode3) begin
      sclk_o = mode3;
      #HALF;
    end
    cs_n_o = 1'b0;
    #HALF;
    for (int i = 0; i < 8 + narg + nrd; i++) begin
      if (i == pause_at) hold_bus();
      if (i < 8) begin
        clk_bit(op[7 - i], r);
      end else if (i < 8 + narg) begin
        clk_bit(arg[31 - i], r);
      end else begin
        clk_bit(~mosi_o, r);
        rd = {rd[6:0], r};
      end
    end
    sclk_o = mode3;
    #HALF;
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #HALF;
  endtask : frame
endmodule : sff_spi_master

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`include "sff_map.svh"
module testbench;
  localparam int PUW = 400;
  logic clk_i;
  logic sys_rst_i;
  logic op_done_i;
  logic wp_n;
  logic junk;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic pause_n;
  logic [3:0] lane_i;
  logic [3:0] lane_o;
  logic [3:0] lane_oe_n_o;
  logic op_start_o;
  sff_pkg::sff_op_e op_kind_o;
  logic [23:0] op_addr_o;
  logic [15:0] status_o;
  logic busy_o;
  logic powered_down_o;
  logic paused_o;
  logic write_ready_o;
  logic [7:0] rd;
  logic [7:0] qops [6] = '{`SFF_OP_DUAL_OUT, `SFF_OP_DUAL_IO, `SFF_OP_QUAD_OUT,
    `SFF_OP_QUAD_IO, `SFF_OP_QUAD_WORD, `SFF_OP_QUAD_OCTAL};
  int qclk [6] = '{40, 24, 40, 20, 18, 16};
  logic [3:0] qoe [6] = '{4'hC, 4'hC, 4'h0, 4'h0, 4'h0, 4'h0};
  int n_fail;
  int num_checks;
  int cycles;
  int starts;
  // Wire levels from the front end's enables, bench drives otherwise
  assign lane_i[0] = (lane_oe_n_o[0] !== 1'b0) ? mosi : lane_o[0];
  assign lane_i[1] = (lane_oe_n_o[1] !== 1'b0) ? junk : lane_o[1];
  assign lane_i[2] = (lane_oe_n_o[2] !== 1'b0) ? wp_n : lane_o[2];
  assign lane_i[3] = (lane_oe_n_o[3] !== 1'b0) ? pause_n : lane_o[3];
  sff_front_end #(.PUW_CYCLES(PUW)) sff_front_end_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .lane_i(lane_i), .lane_o(lane_o), .lane_oe_n_o(lane_oe_n_o),
    .op_done_i(op_done_i), .rd_data_i(8'hA5), .rd_addr_o(), .rd_next_o(), .wr_byte_o(),
    .wr_valid_o(), .op_start_o(op_start_o), .op_kind_o(op_kind_o), .op_addr_o(op_addr_o),
    .suspend_o(), .resume_o(), .status_o(status_o), .busy_o(busy_o),
    .powered_down_o(powered_down_o), .paused_o(paused_o), .write_ready_o(write_ready_o));
  sff_spi_master sff_spi_master_inst (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .pause_n_o(pause_n), .miso_i(lane_i[1]), .paused_i(paused_o), .oe_n_i(lane_oe_n_o));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    junk <= ~junk;
    if (op_start_o === 1'b1) starts <= starts + 1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk_v(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_v
  task automatic chk_b(input string what, input logic exp, input logic got);
    chk_v(what, {23'h000000, exp}, {23'h000000, got});
  endtask : chk_b
  task automatic xfer(input logic [7:0] op, input logic [23:0] arg, input int na, input int nr);
    sff_spi_master_inst.frame(op, arg, na, nr, -1, rd);
  endtask : xfer
  task automatic cmd(input logic [7:0] op);
    xfer(op, 24'h000000, 0, 0);
  endtask : cmd
  task automatic sr1();
    xfer(`SFF_OP_RDSR1, 24'h000000, 0, 8);
  endtask : sr1
  task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi);
    xfer(`SFF_OP_WRSR, {lo, hi, 8'h00}, 16, 0);
  endtask : wrsr
  task automatic finish_op();
    @(posedge clk_i);
    #1 op_done_i = 1'b1;
    @(posedge clk_i);
    #1 op_done_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : finish_op
  task automatic run_lanes(input logic qe);
    foreach (qops[i]) begin
      xfer(qops[i], 24'h000000, 0, qclk[i]);
      chk_v("lane_oe", 24'((!qe && qoe[i] == 4'h0) ? 4'hF : qoe[i]), 24'(sff_spi_master_inst.oe_seen));
    end
  endtask : run_lanes
  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, n_fail);
  endtask : test_end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    sys_rst_i = 1'b1;
    op_done_i = 1'b0;
    wp_n = 1'b1;
    junk = 1'b0;
    n_fail = 0;
    num_checks = 0;
    cycles = 0;
    starts = 0;
    repeat (5) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    chk_v("status", 24'h000000, 24'(status_o));
    chk_v("lane_oe", 24'h00000F, 24'(lane_oe_n_o));
    cmd(`SFF_OP_WREN);
    chk_b("write_ready", 1'b0, write_ready_o);
    chk_b("wel", 1'b0, status_o[`SFF_SR_WEL]);
    repeat (PUW) @(posedge clk_i);
    #1 chk_b("write_ready", 1'b1, write_ready_o);
    test_end("power_up");
    for (int md = 0; md < 2; md++) begin
      sff_spi_master_inst.mode3 = md[0];
      cmd(`SFF_OP_WRDI);
      sr1();
      chk_v("sr1", 24'h000000, 24'(rd));
      chk_v("lane_oe", 24'h00000D, 24'(sff_spi_master_inst.oe_seen));
      cmd(`SFF_OP_WREN);
      sr1();
      chk_v("sr1", 24'h000002, 24'(rd));
    end
    sff_spi_master_inst.mode3 = 1'b0;
    test_end("modes");
    for (int p = 4; p < 16; p += 8) begin
      sff_spi_master_inst.frame(`SFF_OP_RDSR1, 24'h000000, 0, 8, p, rd);
      chk_b("paused", 1'b1, sff_spi_master_inst.paused_seen);
      chk_v("pause_oe", 24'h00000F, 24'(sff_spi_master_inst.pause_oe));
      chk_v("sr1", 24'h000002, 24'(rd));
      chk_b("paused", 1'b0, paused_o);
    end
    test_end("pause");
    cmd(`SFF_OP_WRDI);
    xfer(`SFF_OP_SECTOR, 24'h123456, 24, 0);
    chk_v("starts", 24'h000000, 24'(starts));
    cmd(`SFF_OP_WREN);
    xfer(`SFF_OP_SECTOR, 24'h123456, 24, 0);
    chk_v("starts", 24'h000001, 24'(starts));
    chk_v("op_kind", 24'(sff_pkg::OP_SECTOR), 24'(op_kind_o));
    chk_v("op_addr", 24'h123456, op_addr_o);
    chk_b("busy", 1'b1, busy_o);
    sr1();
    chk_v("sr1", 24'h000003, 24'(rd));
    cmd(`SFF_OP_WRDI);
    cmd(`SFF_OP_PDOWN);
    chk_b("powered_down", 1'b0, powered_down_o);
    chk_v("status", 24'h000003, 24'(status_o));
    cmd(`SFF_OP_SUSPEND);
    chk_v("status", 24'h008002, 24'(status_o));
    cmd(`SFF_OP_RESUME);
    chk_v("status", 24'h000003, 24'(status_o));
    finish_op();
    chk_v("status", 24'h000000, 24'(status_o));
    test_end("erase");
    run_lanes(1'b0);
    cmd(`SFF_OP_WREN);
    wrsr(8'h9C, 8'h00);
    chk_b("busy", 1'b1, busy_o);
    finish_op();
    chk_v("status", 24'h00009C, 24'(status_o));
    wp_n = 1'b0;
    cmd(`SFF_OP_WREN);
    wrsr(8'h00, 8'h00);
    chk_v("status", 24'h00009E, 24'(status_o));
    wp_n = 1'b1;
    wrsr(8'h1C, 8'h02);
    chk_b("busy", 1'b1, busy_o);
    finish_op();
    chk_v("status", 24'h00021C, 24'(status_o));
    run_lanes(1'b1);
    test_end("protect_and_lanes");
    cmd(`SFF_OP_PDOWN);
    chk_b("powered_down", 1'b1, powered_down_o);
    cmd(`SFF_OP_WREN);
    chk_b("wel", 1'b0, status_o[`SFF_SR_WEL]);
    cmd(`SFF_OP_RPDOWN);
    chk_b("powered_down", 1'b0, powered_down_o);
    cmd(`SFF_OP_WREN);
    chk_b("wel", 1'b1, status_o[`SFF_SR_WEL]);
    test_end("power_down");
    sys_rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    chk_v("status", 24'h000000, 24'(status_o));
    chk_b("busy", 1'b0, busy_o);
    test_end("second_reset");
    finish_test();
  end
endmodule : testbench
